// ===== pkg/mdc_params.svh
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH
// Overview of operation
// - bit 10 enables over-temperature sensing, resets zero
// - bit 9 suppresses supply undervoltage fault, reporting
// - bit 8 suppresses gate driver faults, reporting
// - bit 7 clamps amplifier outputs near 3.3 V
// - watchdog runs on bit 3; timeout bits 6:5
// - bit 4 disables shunt overcurrent protection, reporting
// - writing sleep bit one sleeps; zero wakes
// - writing fault clear one clears latched faults
// - bit 0 picks pump undervoltage 4.9/4.6 V
// - per-channel offset calibration bits, reset to one
// - amplifier blanking code selects 0/500ns/2.5us/10us
// - per-channel gain codes give 10/20/40/80 V/V
// - regulator power-down delay after sleep, bits 4:3
// - regulator undervoltage point 10/20/30/30 percent
// - mode 000 latches driver shutdown; level 0x19
// - mode 001 reports overcurrent, drivers keep running
// - mode 010 no overcurrent sensing or reporting
// - entering sleep restores every register default
// - trip above level handled per monitor mode

// register access port geometry
`define MDC_ADDR_W      4
`define MDC_DATA_W      11
// register offsets
`define MDC_OFF_DEVOP   4'h9
`define MDC_OFF_AMP     4'ha
`define MDC_OFF_REG     4'hb
`define MDC_OFF_OCM     4'hc
// reset values
`define MDC_RST_DEVOP   11'h020
`define MDC_RST_AMP     11'h700
`define MDC_RST_REG     11'h10a
`define MDC_RST_OCM     11'h0c8
// device operation fields
`define MDC_B_OTS       10
`define MDC_B_SUPUV     9
`define MDC_B_GATE      8
`define MDC_B_CLAMP     7
`define MDC_F_WD_HI     6
`define MDC_F_WD_LO     5
`define MDC_B_SHUNT     4
`define MDC_B_WDON      3
`define MDC_B_SLEEP     2
`define MDC_B_FCLR      1
`define MDC_B_PUMP      0
// self-acting bits never stored in the word
`define MDC_DEVOP_ACT   11'h006
// amplifier fields
`define MDC_B_CAL3      10
`define MDC_B_CAL2      9
`define MDC_B_CAL1      8
`define MDC_F_BLK_HI    7
`define MDC_F_BLK_LO    6
`define MDC_F_G3_HI     5
`define MDC_F_G3_LO     4
`define MDC_F_G2_HI     3
`define MDC_F_G2_LO     2
`define MDC_F_G1_HI     1
`define MDC_F_G1_LO     0
// regulator fields
`define MDC_F_SCL_HI    9
`define MDC_F_SCL_LO    8
`define MDC_F_SD_HI     4
`define MDC_F_SD_LO     3
`define MDC_B_PGOOD     2
`define MDC_F_UV_HI     1
`define MDC_F_UV_LO     0
`define MDC_UV_MAX      2'h2
// overcurrent monitor fields
`define MDC_F_LVL_HI    7
`define MDC_F_LVL_LO    3
`define MDC_F_MODE_HI   2
`define MDC_F_MODE_LO   0
`define MDC_DS_LATCH    3'h0
`define MDC_DS_REPORT   3'h1
`define MDC_DS_OFF      3'h2
// timing
`define MDC_CLK_HZ      10000000
`define MDC_WD_T0_MS    10
`define MDC_WD_T1_MS    20
`define MDC_WD_T2_MS    50
`define MDC_WD_T3_MS    100
`define MDC_SD_T0_US    0
`define MDC_SD_T1_US    10
`define MDC_SD_T2_US    50
`define MDC_SD_T3_MS    1
`define MDC_TMR_W       20
`endif

// ===== pkg/mdc_pkg.sv
package mdc_pkg;
  typedef logic [10:0] mdc_word_t;
  typedef logic [3:0]  mdc_addr_t;

  // decoded analog and protection controls
  typedef struct packed {
    logic       overtempSenseEnable;
    logic       ampClampEnable;
    logic       pumpUndervoltLevel;
    logic [2:0] ampOffsetCal;
    logic [1:0] ampBlankSel;
    logic [1:0] ampGainCh3;
    logic [1:0] ampGainCh2;
    logic [1:0] ampGainCh1;
    logic [1:0] refScaleSel;
    logic       regulatorGoodDisable;
    logic [1:0] regulatorUndervoltPoint;
    logic [4:0] drainSourceTripLevel;
    logic [2:0] drainSourceProtectMode;
  } mdc_ctrl_s;

  // fault sources, raw in and latched out
  typedef struct packed {
    logic overtemp;
    logic supplyUndervolt;
    logic gateFault;
    logic shuntOvercurrent;
    logic drainSourceOvercurrent;
  } mdc_fault_s;

  typedef enum logic [1:0] {
    SLP_AWAKE,
    SLP_WAIT,
    SLP_OFF
  } mdc_sleep_e;
endpackage

// ===== logic/mdc_delay_timer.sv
`timescale 1ns/1ps
// one-shot down counter, restarted by start, halted by stop
module mdc_delay_timer #(
  parameter int W = 20
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] loadValue,
  output logic              running,
  output logic              expired
);
  logic [W-1:0] count_q;   // cycles left
  logic         run_q;     // counting
  wire          atZero = (count_q == '0);
  wire          hit    = run_q & atZero & ~start & ~stop;

  // start wins over expiry so a restart is never lost
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_q <= '0;
      run_q   <= 1'b0;
    end else if (stop) begin
      run_q   <= 1'b0;
    end else if (start) begin
      count_q <= loadValue;
      run_q   <= 1'b1;
    end else if (run_q) begin
      if (atZero)
        run_q <= 1'b0;
      else
        count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign running = run_q;
  assign expired = hit;
endmodule

// ===== logic/mdc_config_regs.sv
`timescale 1ns/1ps
`include "mdc_params.svh"
// configuration register bank of a three-phase gate driver
module mdc_config_regs #(
  parameter int WD_CYC0 = `MDC_WD_T0_MS * (`MDC_CLK_HZ / 1000),
  parameter int WD_CYC1 = `MDC_WD_T1_MS * (`MDC_CLK_HZ / 1000),
  parameter int WD_CYC2 = `MDC_WD_T2_MS * (`MDC_CLK_HZ / 1000),
  parameter int WD_CYC3 = `MDC_WD_T3_MS * (`MDC_CLK_HZ / 1000),
  parameter int SD_CYC3 = `MDC_SD_T3_MS * (`MDC_CLK_HZ / 1000)
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  input  wire mdc_pkg::mdc_addr_t regAddr,
  input  wire mdc_pkg::mdc_word_t regWdata,
  output mdc_pkg::mdc_word_t      regRdata,
  output logic                    regHit,
  input  wire mdc_pkg::mdc_fault_s faultRaw,
  output mdc_pkg::mdc_fault_s     faultLatched,
  output mdc_pkg::mdc_ctrl_s      ctrl,
  output logic                    driverShutdown,
  output logic                    watchdogFault,
  output logic                    faultClear,
  output logic                    deviceAsleep,
  output logic                    regulatorOff
);
  import mdc_pkg::*;

  // short sleep delays stay fixed, long one is a parameter
  localparam int SD_CYC0 = `MDC_SD_T0_US * (`MDC_CLK_HZ / 1000000);
  localparam int SD_CYC1 = `MDC_SD_T1_US * (`MDC_CLK_HZ / 1000000);
  localparam int SD_CYC2 = `MDC_SD_T2_US * (`MDC_CLK_HZ / 1000000);
  localparam int TW      = `MDC_TMR_W;

  // pick one of four cycle counts by a two-bit code
  function automatic logic [TW-1:0] selCount(
    input logic [1:0] code,
    input int c0,
    input int c1,
    input int c2,
    input int c3
  );
    logic [TW-1:0] r;
    r = TW'(c0);
    unique case (code)
      2'h0: r = TW'(c0);
      2'h1: r = TW'(c1);
      2'h2: r = TW'(c2);
      2'h3: r = TW'(c3);
    endcase
    return r;
  endfunction

  // register storage
  mdc_word_t  devOp_q, devOp_d;     // device operation
  mdc_word_t  amp_q,   amp_d;       // current amplifier control
  mdc_word_t  reg_q,   reg_d;       // regulator control
  mdc_word_t  ocm_q,   ocm_d;       // overcurrent monitor control
  mdc_word_t  rdata_q, rdata_d;     // read return word
  mdc_sleep_e slp_q,   slp_d;       // sleep sequencer
  mdc_fault_s flt_q,   flt_d;       // latched reported faults
  logic       shut_q,  shut_d;      // latched driver shutdown
  logic       wdf_q,   wdf_d;       // watchdog expiry flag

  // address decode
  wire selDevOp = (regAddr == `MDC_OFF_DEVOP);
  wire selAmp   = (regAddr == `MDC_OFF_AMP);
  wire selReg   = (regAddr == `MDC_OFF_REG);
  wire selOcm   = (regAddr == `MDC_OFF_OCM);
  wire mapped   = selDevOp | selAmp | selReg | selOcm;
  wire isAwake  = (slp_q == SLP_AWAKE);

  // write strobes; while asleep only the wake write acts
  wire wrDevOp  = regWrite & selDevOp;
  wire wrAwake  = regWrite & isAwake;
  wire sleepReq = wrDevOp & isAwake & regWdata[`MDC_B_SLEEP];
  wire wakeReq  = wrDevOp & ~isAwake & ~regWdata[`MDC_B_SLEEP];
  wire clrReq   = wrDevOp & isAwake & regWdata[`MDC_B_FCLR];

  // sleep entry restores defaults before any further write
  wire loadDflt = sleepReq;

  // next register values
  assign devOp_d = loadDflt ? `MDC_RST_DEVOP :
                   (wrAwake & selDevOp) ? (regWdata & ~`MDC_DEVOP_ACT) :
                   devOp_q;
  assign amp_d   = loadDflt ? `MDC_RST_AMP :
                   (wrAwake & selAmp) ? regWdata : amp_q;
  assign reg_d   = loadDflt ? `MDC_RST_REG :
                   (wrAwake & selReg) ? regWdata : reg_q;
  assign ocm_d   = loadDflt ? `MDC_RST_OCM :
                   (wrAwake & selOcm) ? regWdata : ocm_q;

  // read word; sleep state shows in its bit, clear bit reads zero
  wire mdc_word_t devOpRd = devOp_q |
    (isAwake ? 11'h000 : (11'h001 << `MDC_B_SLEEP));
  assign rdata_d = ~regRead ? rdata_q :
                   selDevOp ? devOpRd :
                   selAmp   ? amp_q :
                   selReg   ? reg_q :
                   selOcm   ? ocm_q : 11'h000;

  // register bank and read holding register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      devOp_q <= `MDC_RST_DEVOP;
      amp_q   <= `MDC_RST_AMP;
      reg_q   <= `MDC_RST_REG;
      ocm_q   <= `MDC_RST_OCM;
      rdata_q <= 11'h000;
    end else begin
      devOp_q <= devOp_d;
      amp_q   <= amp_d;
      reg_q   <= reg_d;
      ocm_q   <= ocm_d;
      rdata_q <= rdata_d;
    end
  end

  // decoded controls, straight from the flops
  wire [1:0] uvCode = reg_q[`MDC_F_UV_HI:`MDC_F_UV_LO];
  // code 11 means the same as 10, so the analog side sees one code
  wire [1:0] uvNorm = (uvCode > `MDC_UV_MAX) ? `MDC_UV_MAX : uvCode;
  assign ctrl.overtempSenseEnable  = devOp_q[`MDC_B_OTS];
  assign ctrl.ampClampEnable       = devOp_q[`MDC_B_CLAMP];
  assign ctrl.pumpUndervoltLevel   = devOp_q[`MDC_B_PUMP];
  assign ctrl.ampOffsetCal         = {amp_q[`MDC_B_CAL3],
                                      amp_q[`MDC_B_CAL2],
                                      amp_q[`MDC_B_CAL1]};
  assign ctrl.ampBlankSel  = amp_q[`MDC_F_BLK_HI:`MDC_F_BLK_LO];
  assign ctrl.ampGainCh3   = amp_q[`MDC_F_G3_HI:`MDC_F_G3_LO];
  assign ctrl.ampGainCh2   = amp_q[`MDC_F_G2_HI:`MDC_F_G2_LO];
  assign ctrl.ampGainCh1   = amp_q[`MDC_F_G1_HI:`MDC_F_G1_LO];
  assign ctrl.refScaleSel  = reg_q[`MDC_F_SCL_HI:`MDC_F_SCL_LO];
  assign ctrl.regulatorGoodDisable    = reg_q[`MDC_B_PGOOD];
  assign ctrl.regulatorUndervoltPoint = uvNorm;
  assign ctrl.drainSourceTripLevel =
    ocm_q[`MDC_F_LVL_HI:`MDC_F_LVL_LO];
  assign ctrl.drainSourceProtectMode =
    ocm_q[`MDC_F_MODE_HI:`MDC_F_MODE_LO];

  // protection gating; reserved mode codes behave as disabled
  wire [2:0] dsMode    = ctrl.drainSourceProtectMode;
  wire       dsLatch   = (dsMode == `MDC_DS_LATCH);
  wire       dsReport  = dsLatch | (dsMode == `MDC_DS_REPORT);
  // mode 010 and reserved codes leave dsReport low
  wire mdc_fault_s gated;
  assign gated.overtemp         = faultRaw.overtemp &
                                  devOp_q[`MDC_B_OTS];
  assign gated.supplyUndervolt  = faultRaw.supplyUndervolt &
                                  ~devOp_q[`MDC_B_SUPUV];
  assign gated.gateFault        = faultRaw.gateFault &
                                  ~devOp_q[`MDC_B_GATE];
  assign gated.shuntOvercurrent = faultRaw.shuntOvercurrent &
                                  ~devOp_q[`MDC_B_SHUNT];
  assign gated.drainSourceOvercurrent =
    faultRaw.drainSourceOvercurrent & dsReport;

  // latched faults: a new event in the clear cycle still sets
  assign flt_d  = gated | (clrReq ? '0 : flt_q);
  assign shut_d = (faultRaw.drainSourceOvercurrent & dsLatch) |
                  (shut_q & ~clrReq);

  // watchdog: any register access restarts it
  logic wdRunning;
  logic wdExpired;
  wire  wdOn    = devOp_q[`MDC_B_WDON] & isAwake;
  wire  hostHit = (regWrite | regRead) & mapped;
  wire  wdStart = wdOn & (hostHit | ~wdRunning);
  wire [TW-1:0] wdLoad = selCount(
    devOp_q[`MDC_F_WD_HI:`MDC_F_WD_LO],
    WD_CYC0, WD_CYC1, WD_CYC2, WD_CYC3);
  assign wdf_d = wdExpired | (wdf_q & ~clrReq);

  mdc_delay_timer #(
    .W         (TW)
  ) u_wd_timer (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .start     (wdStart),
    .stop      (~wdOn),
    .loadValue (wdLoad),
    .running   (wdRunning),
    .expired   (wdExpired)
  );

  // regulator power-down delay, taken from the value before defaults
  logic sdExpired;
  wire [TW-1:0] sdLoad = selCount(
    reg_q[`MDC_F_SD_HI:`MDC_F_SD_LO],
    SD_CYC0, SD_CYC1, SD_CYC2, SD_CYC3);

  mdc_delay_timer #(
    .W         (TW)
  ) u_sleep_timer (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .start     (sleepReq),
    .stop      (wakeReq),
    .loadValue (sdLoad),
    .running   (),
    .expired   (sdExpired)
  );

  // sleep sequencer
  always_comb begin
    slp_d = slp_q;
    unique case (slp_q)
      SLP_AWAKE: if (sleepReq) slp_d = SLP_WAIT;
      SLP_WAIT: begin
        if (wakeReq)
          slp_d = SLP_AWAKE;
        else if (sdExpired)
          slp_d = SLP_OFF;
      end
      SLP_OFF: if (wakeReq) slp_d = SLP_AWAKE;
      default: slp_d = SLP_AWAKE;
    endcase
  end

  // state and flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slp_q  <= SLP_AWAKE;
      flt_q  <= '0;
      shut_q <= 1'b0;
      wdf_q  <= 1'b0;
    end else begin
      slp_q  <= slp_d;
      flt_q  <= flt_d;
      shut_q <= shut_d;
      wdf_q  <= wdf_d;
    end
  end

  // outputs
  assign regRdata       = rdata_q;
  assign regHit         = mapped;
  assign faultLatched   = flt_q;
  assign driverShutdown = shut_q;
  assign watchdogFault  = wdf_q;
  assign faultClear     = clrReq;
  assign deviceAsleep   = ~isAwake;
  assign regulatorOff   = (slp_q == SLP_OFF);

  // checks
  property p_ots_gate;
    @(posedge clock) disable iff (sys_rst)
      (faultRaw.overtemp & ~devOp_q[`MDC_B_OTS] & ~flt_q.overtemp)
      |=> ~flt_q.overtemp;
  endproperty
  a_ots_gate: assert property (p_ots_gate)
    else $error("overtemp latched while sensing off");

  property p_uv_suppress;
    @(posedge clock) disable iff (sys_rst)
      (faultRaw.supplyUndervolt & ~devOp_q[`MDC_B_SUPUV])
      |=> flt_q.supplyUndervolt;
  endproperty
  a_uv_suppress: assert property (p_uv_suppress)
    else $error("supply undervolt not latched");

  property p_gate_suppress;
    @(posedge clock) disable iff (sys_rst)
      (devOp_q[`MDC_B_GATE] & ~flt_q.gateFault & ~sleepReq)
      |=> ~flt_q.gateFault;
  endproperty
  a_gate_suppress: assert property (p_gate_suppress)
    else $error("gate fault reported while disabled");

  property p_wd_off;
    @(posedge clock) disable iff (sys_rst)
      ~devOp_q[`MDC_B_WDON] |=> ~wdRunning;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog runs while disabled");

  property p_clear;
    @(posedge clock) disable iff (sys_rst)
      (clrReq & ~faultRaw.gateFault) |=> ~flt_q.gateFault;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault clear did not clear");

  property p_sleep_dflt;
    @(posedge clock) disable iff (sys_rst)
      sleepReq |=> (amp_q == `MDC_RST_AMP) && (ocm_q == `MDC_RST_OCM)
                   && deviceAsleep;
  endproperty
  a_sleep_dflt: assert property (p_sleep_dflt)
    else $error("defaults not restored on sleep");

  property p_sd_zero;
    @(posedge clock) disable iff (sys_rst)
      (sleepReq & (reg_q[`MDC_F_SD_HI:`MDC_F_SD_LO] == 2'h0))
      |-> ##2 (regulatorOff | isAwake);
  endproperty
  a_sd_zero: assert property (p_sd_zero)
    else $error("zero delay power-down late");

  property p_sd_ten;
    @(posedge clock) disable iff (sys_rst)
      (sleepReq & (reg_q[`MDC_F_SD_HI:`MDC_F_SD_LO] == 2'h1))
      |=> ~regulatorOff [*8];
  endproperty
  a_sd_ten: assert property (p_sd_ten)
    else $error("regulator off too early");

  property p_ds_latch;
    @(posedge clock) disable iff (sys_rst)
      (faultRaw.drainSourceOvercurrent & dsLatch)
      |=> driverShutdown & flt_q.drainSourceOvercurrent;
  endproperty
  a_ds_latch: assert property (p_ds_latch)
    else $error("overcurrent did not latch shutdown");

  property p_ds_report;
    @(posedge clock) disable iff (sys_rst)
      (dsMode == `MDC_DS_REPORT && !driverShutdown && !sleepReq)
      |=> !driverShutdown;
  endproperty
  a_ds_report: assert property (p_ds_report)
    else $error("report mode shut the drivers");

  property p_ds_off;
    @(posedge clock) disable iff (sys_rst)
      (dsMode == `MDC_DS_OFF && !flt_q.drainSourceOvercurrent)
      |=> !flt_q.drainSourceOvercurrent;
  endproperty
  a_ds_off: assert property (p_ds_off)
    else $error("overcurrent reported while off");
endmodule

// ===== tb/mdc_host_model.sv
`timescale 1ns/1ps
`include "mdc_params.svh"
// host side of the register port, acting just after each rising edge
module mdc_host_model (
  input  wire logic               clock,
  output logic                    regWrite,
  output logic                    regRead,
  output mdc_pkg::mdc_addr_t      regAddr,
  output mdc_pkg::mdc_word_t      regWdata,
  input  wire mdc_pkg::mdc_word_t regRdata
);
  import mdc_pkg::*;
  // idle bus: strobes low
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 4'h0;
    regWdata = 11'h000;
  end
  // one write, request held over exactly one sampling edge
  task automatic wr(input mdc_addr_t a, input mdc_word_t d);
    @(posedge clock);
    #1;
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    regWdata = ~d; // stale data must not look valid
  endtask
  // one read, data taken once the read edge has landed
  task automatic rd(input mdc_addr_t a, output mdc_word_t d);
    @(posedge clock);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    d       = regRdata;
  endtask
  // sleep request or wake, other control bits kept from base
  task automatic sleep(input mdc_word_t base, input logic on);
    wr(`MDC_OFF_DEVOP, base | (on ? 11'h004 : 11'h000));
  endtask
  // fault clear is a self-acting bit on top of base
  task automatic clearFaults(input mdc_word_t base);
    wr(`MDC_OFF_DEVOP, base | 11'h002);
  endtask
endmodule

// ===== tb/mdc_config_regs_tb.sv
`timescale 1ns/1ps
`include "mdc_params.svh"
`define CHK(got, exp, msg) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); \
  end \
end
// self-checking bench of the configuration register bank
module mdc_config_regs_tb;
  import mdc_pkg::*;
  // shortened watchdog counts keep the run brief
  int          wdc[4] = '{20, 40, 60, 80};
  logic        clock;
  logic        sysRst;
  logic        regWrite;
  logic        regRead;
  mdc_addr_t   regAddr;
  mdc_word_t   regWdata;
  mdc_word_t   regRdata;
  logic        regHit;
  mdc_fault_s  faultRaw;
  mdc_fault_s  faultLatched;
  mdc_ctrl_s   ctrl;
  logic        driverShutdown;
  logic        watchdogFault;
  logic        faultClear;
  logic        deviceAsleep;
  logic        regulatorOff;
  int          bad_count;
  int          num_checks;
  mdc_word_t   mdl[4];   // expected register words
  logic [15:0] lfsr;
  mdc_word_t   rv;
  int          i;
  mdc_host_model u_host (
    .clock    (clock),
    .regWrite (regWrite),
    .regRead  (regRead),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regRdata (regRdata)
  );
  mdc_config_regs #(
    .WD_CYC0 (20), .WD_CYC1 (40), .WD_CYC2 (60), .WD_CYC3 (80),
    .SD_CYC3 (300)
  ) u_dut (
    .clock (clock), .sys_rst (sysRst), .regWrite (regWrite),
    .regRead (regRead), .regAddr (regAddr), .regWdata (regWdata),
    .regRdata (regRdata), .regHit (regHit), .faultRaw (faultRaw),
    .faultLatched (faultLatched), .ctrl (ctrl),
    .driverShutdown (driverShutdown), .watchdogFault (watchdogFault),
    .faultClear (faultClear), .deviceAsleep (deviceAsleep),
    .regulatorOff (regulatorOff)
  );
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // random source, maximal-length taps
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // every register back to its power-up word
  task automatic mdlReset();
    mdl[0] = `MDC_RST_DEVOP;
    mdl[1] = `MDC_RST_AMP;
    mdl[2] = `MDC_RST_REG;
    mdl[3] = `MDC_RST_OCM;
  endtask
  // decoded controls as the model words imply
  function automatic mdc_ctrl_s expCtrl();
    mdc_ctrl_s c;
    c.overtempSenseEnable     = mdl[0][10];
    c.ampClampEnable          = mdl[0][7];
    c.pumpUndervoltLevel      = mdl[0][0];
    c.ampOffsetCal            = mdl[1][10:8];
    c.ampBlankSel             = mdl[1][7:6];
    c.ampGainCh3              = mdl[1][5:4];
    c.ampGainCh2              = mdl[1][3:2];
    c.ampGainCh1              = mdl[1][1:0];
    c.refScaleSel             = mdl[2][9:8];
    c.regulatorGoodDisable    = mdl[2][2];
    // top undervoltage code folds onto the 30 percent point
    c.regulatorUndervoltPoint = (mdl[2][1:0] == 2'h3) ? 2'h2 : mdl[2][1:0];
    c.drainSourceTripLevel    = mdl[3][7:3];
    c.drainSourceProtectMode  = mdl[3][2:0];
    return c;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chkReg(input int k);
    mdc_word_t v;
    u_host.rd(mdc_addr_t'(k + 9), v);
    `CHK(v, mdl[k], "readback")
    `CHK(regHit, 1'b1, "hit")
  endtask
  task automatic chkAll();
    for (int k = 0; k < 4; k++) chkReg(k);
    `CHK(ctrl, expCtrl(), "ctrl")
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run of about one thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    sysRst = 1'b1;
    faultRaw = 5'h00;
    bad_count = 0;
    num_checks = 0;
    lfsr = 16'd45;
    mdlReset();
    cyc(20);
    sysRst = 1'b0;
    // reset words and unmapped places
    chkAll();
    u_host.rd(4'h0, rv);
    `CHK(rv, 11'h000, "unmapped")
    `CHK(regHit, 1'b0, "nohit")
    u_host.wr(4'hd, 11'h7ff);
    chkAll();
    $display("test reset done");
    // random words, reserved codes steered clear
    for (int k = 0; k < 16; k++) begin
      i = k % 4;
      lfsr = nxt(lfsr);
      rv = lfsr[10:0];
      faultRaw = lfsr[15:11];
      if (i == 0) rv = rv & 11'h7f1; // no watchdog, sleep or clear
      if (i == 2) rv[9:8] = rv[8] ? 2'h1 : 2'h2;
      if (i == 3) rv[2:0] = rv[2:0] % 3;
      u_host.wr(mdc_addr_t'(i + 9), rv);
      mdl[i] = rv;
      if (i == 3) chkAll();
    end
    // random fault levels may have latched; start the fault test clean
    faultRaw = 5'h00;
    u_host.clearFaults(`MDC_RST_DEVOP);
    `CHK(faultLatched, 5'h00, "rand clr")
    $display("test random done");
    // fault gating and clearing
    mdlReset();
    for (int k = 0; k < 4; k++) u_host.wr(mdc_addr_t'(k + 9), mdl[k]);
    faultRaw = 5'h1f;
    cyc(3);
    `CHK(faultLatched, 5'h0f, "faults on")
    `CHK(driverShutdown, 1'b1, "latched")
    faultRaw = 5'h00;
    u_host.clearFaults(11'h020);
    cyc(2);
    `CHK(faultLatched, 5'h00, "cleared")
    `CHK(driverShutdown, 1'b0, "unlatch")
    mdl[0] = 11'h730;
    u_host.wr(`MDC_OFF_DEVOP, mdl[0]);
    faultRaw = 5'h1e;
    cyc(3);
    `CHK(faultLatched, 5'h10, "gated")
    faultRaw = 5'h00;
    // drain-source monitor modes
    for (int m = 0; m < 3; m++) begin
      mdl[3] = {3'h0, 5'h19, 3'(m)};
      u_host.clearFaults(mdl[0]);
      u_host.wr(`MDC_OFF_OCM, mdl[3]);
      faultRaw = 5'h01;
      cyc(3);
      faultRaw = 5'h00;
      cyc(2);
      `CHK(driverShutdown, m == 0, "shutdown")
      `CHK(faultLatched.drainSourceOvercurrent, m != 2, "ds")
    end
    chkAll();
    $display("test faults done");
    // watchdog timeout for each code
    for (int c = 0; c < 4; c++) begin
      u_host.wr(`MDC_OFF_DEVOP, 11'h008 | mdc_word_t'(c << 5));
      cyc(wdc[c] - 4);
      `CHK(watchdogFault, 1'b0, "wd early")
      cyc(8);
      `CHK(watchdogFault, 1'b1, "wd late")
      u_host.wr(`MDC_OFF_DEVOP, 11'h000);
      u_host.clearFaults(11'h000);
    end
    cyc(90);
    `CHK(watchdogFault, 1'b0, "wd off")
    $display("test watchdog done");
    // sleep: defaults restored, delayed regulator power-down
    mdl[0] = 11'h020;
    u_host.wr(`MDC_OFF_AMP, 11'h0ff);
    u_host.wr(`MDC_OFF_REG, 11'h112);
    u_host.sleep(11'h020, 1'b1);
    `CHK(deviceAsleep, 1'b1, "asleep")
    cyc(400);
    `CHK(regulatorOff, 1'b0, "reg early")
    cyc(120);
    `CHK(regulatorOff, 1'b1, "reg off")
    u_host.wr(`MDC_OFF_AMP, 11'h0ff);
    mdlReset();
    mdl[0] = 11'h024;
    chkAll();
    u_host.sleep(11'h020, 1'b0);
    `CHK(deviceAsleep, 1'b0, "awake")
    mdl[0] = 11'h020;
    chkAll();
    $display("test sleep done");
    results();
  end
endmodule
